// ---- asp_fifo.sv ----
// sample fifo with registered output stage
module asp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0] cnt;
  logic push, pop;

  // honest full: ready only while storage has room
  assign o_in_ready = cnt != FULL;
  assign push = i_in_valid && o_in_ready;
  assign pop = (cnt != '0) && (!o_out_valid || i_out_ready);

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wp] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end else if (i_ce) begin
      if (push) wp <= wrap_inc(wp);
      if (pop) rp <= wrap_inc(rp);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        o_out_valid <= 1'b1;
        o_out_data <= mem[rp];
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule // asp_fifo

// ---- asp_pkg.sv ----
// shared constants and types for the sample playback front end
package asp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_LOOP_START = 8'h08;
  localparam logic [7:0] REG_LOOP_END = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ENC_IN = 8'h14;
  localparam logic [7:0] REG_ENC_CODE = 8'h18;
  localparam logic [7:0] REG_DEC_STATE = 8'h1c;

  // control register fields
  localparam int CTRL_KEY_ON_BIT = 0;
  localparam int CTRL_LOOP_BIT = 1;
  localparam int CTRL_FMT_LSB = 2;
  localparam int CTRL_KEY_OFF_BIT = 4;
  localparam int CTRL_ENC_CLR_BIT = 5;

  // sample_format_select codes
  localparam logic [1:0] FMT_PCM16 = 2'h0;
  localparam logic [1:0] FMT_PCM8 = 2'h1;
  localparam logic [1:0] FMT_ADPCM = 2'h2;
  localparam logic [1:0] FMT_ADPCM_LONG = 2'h3;

  // ****************************************
  // codec constants
  // ****************************************
  localparam logic [14:0] WIDTH_INIT = 15'h007f;
  localparam logic [14:0] WIDTH_MAX = 15'h6000;
  localparam logic [14:0] WIDTH_MIN = 15'h007f;
  localparam logic [15:0] PRED_INIT = 16'h0000;
  // width factors scaled by 256 and truncated, only F_GROW2 exact
  localparam logic [9:0] F_SHRINK = 10'h0e6;
  localparam logic [9:0] F_GROW0 = 10'h133;
  localparam logic [9:0] F_GROW1 = 10'h199;
  localparam logic [9:0] F_GROW2 = 10'h200;
  localparam logic [9:0] F_GROW3 = 10'h266;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic signed [15:0] pred;
    logic [14:0] width;
  } asp_codec_type;

  localparam asp_codec_type CODEC_INIT = '{pred: PRED_INIT, width: WIDTH_INIT};

endpackage

// ---- asp_playback.sv ----
// sample fetch, unpack, loop addressing and adpcm codec
// Contract
// - unpack nibbles, bytes or words, low first
// - loop off: one sample per step, stop
// - loop on: repeat loop region forever
// - loop start value equals loop end value
// - adpcm decoding starts only at key-on
// - four-bit code expands to sixteen-bit sample
// - encoder sign bit set when difference negative
// - encoder magnitude from quarter-width thresholds
// - decoded value adds signed scaled width
// - width scaled by magnitude-selected factor
// - codec starts at zero and width 127
// - width clamped at 24576
module asp_playback #(
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_STEP,
  output logic O_MEM_REQ,
  output logic [21:0] O_MEM_ADDR,
  input wire logic I_MEM_ACK,
  input wire logic [15:0] I_MEM_DATA,
  output logic O_SMP_VALID,
  output logic [15:0] O_SMP_DATA,
  input wire logic I_SMP_READY,
  output logic O_PLAYING
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FETCH, ST_PUSH} asp_state_type;

  // ****************************************
  // codec arithmetic
  // ****************************************
  function automatic asp_pkg::asp_codec_type codec_step(
    input asp_pkg::asp_codec_type s, input logic [3:0] code);
    logic [18:0] prod;
    logic [15:0] inc;
    logic [17:0] sum;
    logic [9:0] f;
    logic [23:0] wprod;
    logic [15:0] wnew;
    asp_pkg::asp_codec_type r;
    // (mag/4 + 1/8) * width, as (2*mag + 1) * width / 8
    prod = 19'(s.width) * 19'({code[2:0], 1'b1});
    inc = prod[18:3];
    sum = code[3] ? 18'(s.pred) - {2'b00, inc} : 18'(s.pred) + {2'b00, inc};
    if (sum[17:15] == 3'b000 || sum[17:15] == 3'b111) begin
      r.pred = sum[15:0];
    end else begin
      r.pred = sum[17] ? 16'h8000 : 16'h7fff;
    end
    case (code[2:0])
      3'h4: f = asp_pkg::F_GROW0;
      3'h5: f = asp_pkg::F_GROW1;
      3'h6: f = asp_pkg::F_GROW2;
      3'h7: f = asp_pkg::F_GROW3;
      default: f = asp_pkg::F_SHRINK;
    endcase
    wprod = 24'(s.width) * 24'(f);
    wnew = wprod[23:8];
    // lower clamp keeps the width from collapsing to zero
    // width upper clamp
    if (wnew > 16'(asp_pkg::WIDTH_MAX)) begin
      r.width = asp_pkg::WIDTH_MAX;
    end else if (wnew < 16'(asp_pkg::WIDTH_MIN)) begin
      r.width = asp_pkg::WIDTH_MIN;
    end else begin
      r.width = wnew[14:0];
    end
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic loop_on;
  logic [1:0] fmt;
  logic [22:0] start_addr;
  logic [15:0] loop_start;
  logic [15:0] loop_end;
  logic [15:0] idx;
  asp_state_type state, next_state;
  logic step_pend;
  logic [15:0] smp_word;
  asp_pkg::asp_codec_type dec, enc;
  logic [3:0] enc_code;
  logic fifo_in_ready;

  // ****************************************
  // register decode
  // ****************************************
  logic wr_ctrl, key_on, key_off, enc_clr, wr_enc;
  assign wr_ctrl = I_WR && I_ADDR == asp_pkg::REG_CTRL;
  assign key_on = wr_ctrl && I_WDATA[asp_pkg::CTRL_KEY_ON_BIT];
  assign key_off = wr_ctrl && I_WDATA[asp_pkg::CTRL_KEY_OFF_BIT];
  assign enc_clr = wr_ctrl && I_WDATA[asp_pkg::CTRL_ENC_CLR_BIT];
  assign wr_enc = I_WR && I_ADDR == asp_pkg::REG_ENC_IN;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      loop_on <= 1'b0;
      fmt <= asp_pkg::FMT_PCM16;
      start_addr <= '0;
      loop_start <= '0;
      loop_end <= '0;
    end else if (I_CE && I_WR) begin
      if (wr_ctrl) begin
        loop_on <= I_WDATA[asp_pkg::CTRL_LOOP_BIT];
        fmt <= I_WDATA[asp_pkg::CTRL_FMT_LSB +: 2];
      end
      if (I_ADDR == asp_pkg::REG_START) start_addr <= I_WDATA[22:0];
      if (I_ADDR == asp_pkg::REG_LOOP_START) loop_start <= I_WDATA[15:0];
      if (I_ADDR == asp_pkg::REG_LOOP_END) loop_end <= I_WDATA[15:0];
    end
  end

  // ****************************************
  // fetch addressing and unpacking
  // ****************************************
  logic [15:0] word_off, nib_shift, fetched, next_idx;
  logic [7:0] byte_sel;
  logic [21:0] next_mem_addr;
  logic got_word, push_done, at_end, take_step, next_pend;
  asp_pkg::asp_codec_type dec_next;

  assign word_off = (fmt == asp_pkg::FMT_PCM16) ? idx :
                    (fmt == asp_pkg::FMT_PCM8) ? {1'b0, idx[15:1]} : {2'b00, idx[15:2]};
  assign next_mem_addr = start_addr[22:1] + {6'h00, word_off};
  assign nib_shift = I_MEM_DATA >> {idx[1:0], 2'b00};
  assign byte_sel = idx[0] ? I_MEM_DATA[15:8] : I_MEM_DATA[7:0];
  assign dec_next = codec_step(dec, nib_shift[3:0]);
  // eight-bit samples are left-justified into the sixteen-bit path
  assign fetched = (fmt == asp_pkg::FMT_PCM16) ? I_MEM_DATA :
                   (fmt == asp_pkg::FMT_PCM8) ? {byte_sel, 8'h00} : dec_next.pred;

  assign got_word = state == ST_FETCH && I_MEM_ACK;
  assign push_done = state == ST_PUSH && fifo_in_ready;
  assign at_end = idx == loop_end;
  // start sample skipped, it equals the end sample
  assign next_idx = at_end ? loop_start + 16'h0001 : idx + 16'h0001;
  assign take_step = state == ST_WAIT && (step_pend || I_STEP);
  // a step arriving while busy is held, not lost
  assign next_pend = (step_pend && !take_step) || (I_STEP && !(take_step && !step_pend));

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_WAIT: if (take_step) next_state = ST_FETCH;
      ST_FETCH: if (I_MEM_ACK) next_state = ST_PUSH;
      ST_PUSH: if (fifo_in_ready) next_state = (at_end && !loop_on) ? ST_IDLE : ST_WAIT;
      default: next_state = ST_IDLE;
    endcase
    if (key_on) begin
      next_state = ST_WAIT;
    end else if (key_off) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_IDLE;
      step_pend <= 1'b0;
      O_MEM_REQ <= 1'b0;
      O_MEM_ADDR <= '0;
      O_PLAYING <= 1'b0;
    end else if (I_CE) begin
      state <= next_state;
      step_pend <= key_on ? 1'b0 : next_pend;
      O_MEM_REQ <= next_state == ST_FETCH;
      if (state != ST_FETCH) O_MEM_ADDR <= next_mem_addr;
      O_PLAYING <= next_state != ST_IDLE;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      idx <= '0;
      smp_word <= '0;
    end else if (I_CE) begin
      if (key_on) idx <= '0;
      else if (push_done) idx <= next_idx;
      if (got_word) smp_word <= fetched;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      dec <= asp_pkg::CODEC_INIT;
    end else if (I_CE) begin
      if (key_on) dec <= asp_pkg::CODEC_INIT;
      else if (got_word && fmt[1]) dec <= dec_next;
    end
  end

  // ****************************************
  // encoder
  // ****************************************
  logic [16:0] enc_diff, enc_abs;
  logic [6:0] enc_cmp;
  logic [2:0] enc_mag;
  logic [3:0] next_enc_code;

  assign enc_diff = 17'({I_WDATA[15], I_WDATA[15:0]}) - 17'({enc.pred[15], enc.pred});
  assign enc_abs = enc_diff[16] ? 17'h00000 - enc_diff : enc_diff;

  for (genvar k = 1; k <= 7; k++) begin : g_thr
    assign enc_cmp[k-1] = {enc_abs, 2'b00} >= 19'(enc.width) * 19'(k);
  end

  always_comb begin
    enc_mag = 3'h0;
    for (int j = 0; j < 7; j++) begin
      if (enc_cmp[j]) enc_mag = 3'(j + 1);
    end
  end

  assign next_enc_code = {enc_diff[16], enc_mag};

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      enc <= asp_pkg::CODEC_INIT;
      enc_code <= '0;
    end else if (I_CE) begin
      if (enc_clr) begin
        enc <= asp_pkg::CODEC_INIT;
      end else if (wr_enc) begin
        enc <= codec_step(enc, next_enc_code);
        enc_code <= next_enc_code;
      end
    end
  end

  // ****************************************
  // read back and output buffer
  // ****************************************
  logic [31:0] rd_mux;
  assign rd_mux =
    (I_ADDR == asp_pkg::REG_CTRL) ? {28'h0000000, fmt, loop_on, 1'b0} :
    (I_ADDR == asp_pkg::REG_START) ? {9'h000, start_addr} :
    (I_ADDR == asp_pkg::REG_LOOP_START) ? {16'h0000, loop_start} :
    (I_ADDR == asp_pkg::REG_LOOP_END) ? {16'h0000, loop_end} :
    (I_ADDR == asp_pkg::REG_STATUS) ? {15'h0000, state != ST_IDLE, idx} :
    (I_ADDR == asp_pkg::REG_ENC_CODE) ? {enc.pred, 12'h000, enc_code} :
    (I_ADDR == asp_pkg::REG_DEC_STATE) ? {dec.pred, 1'b0, dec.width} : 32'h00000000;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) O_RDATA <= '0;
    else if (I_CE) O_RDATA <= I_RD ? rd_mux : 32'h00000000;
  end

  // a full buffer stalls the fetch engine in the push state
  asp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_in_valid(state == ST_PUSH),
    .o_in_ready(fifo_in_ready),
    .i_in_data(smp_word),
    .o_out_valid(O_SMP_VALID),
    .i_out_ready(I_SMP_READY),
    .o_out_data(O_SMP_DATA)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  word_unpack_a: assert property (
    I_CE && got_word && fmt == asp_pkg::FMT_PCM8
    |=> smp_word[15:8] == ($past(idx[0]) ? $past(I_MEM_DATA[15:8]) : $past(I_MEM_DATA[7:0])))
    else $error("byte unpack order wrong");
  index_step_a: assert property (
    I_CE && push_done && !at_end && !key_on |=> idx == $past(idx) + 16'h0001)
    else $error("index did not advance by one");
  play_stop_a: assert property (
    I_CE && push_done && at_end && !loop_on && !key_on |=> !O_PLAYING ##1 !O_MEM_REQ)
    else $error("playback did not stop at loop end");
  loop_wrap_a: assert property (
    I_CE && push_done && at_end && loop_on && !key_on && !key_off
    |=> idx == $past(loop_start) + 16'h0001 && O_PLAYING)
    else $error("loop wrap wrong");
  keyon_init_a: assert property (
    I_CE && key_on |=> idx == 16'h0000 && dec == asp_pkg::CODEC_INIT && state == ST_WAIT)
    else $error("key-on did not reinitialise");
  width_bound_a: assert property (
    dec.width <= asp_pkg::WIDTH_MAX && enc.width <= asp_pkg::WIDTH_MAX)
    else $error("quantization width above limit");
  dec_sign_a: assert property (
    I_CE && got_word && fmt[1] && !key_on
    |=> ($past(nib_shift[3]) ? dec.pred < $past(dec.pred) : dec.pred > $past(dec.pred))
        || dec.pred == 16'h7fff || dec.pred == 16'h8000)
    else $error("decoded step has wrong direction");
  width_grow_a: assert property (
    I_CE && got_word && fmt[1] && !key_on
    |=> ($past(nib_shift[2]) ? dec.width > $past(dec.width) || dec.width == asp_pkg::WIDTH_MAX
                             : dec.width < $past(dec.width) || dec.width == asp_pkg::WIDTH_MIN))
    else $error("width factor applied wrongly");
  enc_sign_a: assert property (
    I_CE && wr_enc && !enc_clr
    |=> enc_code[3] == ($signed($past(I_WDATA[15:0])) < $past(enc.pred)))
    else $error("encoder sign bit wrong");
  step_fetch_a: assert property (
    I_CE && take_step && !key_on && !key_off |=> O_MEM_REQ && O_MEM_ADDR == $past(next_mem_addr))
    else $error("step did not start a fetch");
endmodule // asp_playback

// ---- asp_playback_tb.sv ----
// self-checking bench for the sample playback front end
module asp_playback_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic step_p = 1'b0;
  logic smp_ready = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic mem_req, mem_ack, smp_valid, playing;
  logic [21:0] mem_addr;
  logic [15:0] mem_data, smp_data;
  logic [15:0] got [$];
  int miscompares = 0;
  int tests_run = 0;
  int m_pred, m_width;
  int fac [4] = '{32'h133, 32'h199, 32'h200, 32'h266};
  logic [15:0] adp_w [3] = '{16'h7777, 16'h7777, 16'hf0f8};
  logic [15:0] enc_in [4] = '{16'h00df, 16'h009f, 16'hff21, 16'hffff};
  logic [31:0] enc_exp [4] = '{32'h00ee0007, 32'h00ae0005, 32'hff12000f, 32'hfff10008};
  always #2.5 clk = ~clk;
  asp_playback asp_playback_i (.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_STEP(step_p),
    .O_MEM_REQ(mem_req), .O_MEM_ADDR(mem_addr), .I_MEM_ACK(mem_ack), .I_MEM_DATA(mem_data),
    .O_SMP_VALID(smp_valid), .O_SMP_DATA(smp_data), .I_SMP_READY(smp_ready),
    .O_PLAYING(playing));
  asp_wave_mem asp_wave_mem_i (.i_clk(clk), .i_rst(rst), .i_delay(dly), .i_req(mem_req),
    .i_addr(mem_addr), .o_ack(mem_ack), .o_data(mem_data));
  always @(posedge clk) begin
    if (smp_valid === 1'b1 && smp_ready) begin
      got.push_back(smp_data);
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // decoder reference: magnitude scaled first, then signed, so rounding is symmetric
  function automatic logic [15:0] adp(input logic [3:0] c);
    int dd;
    dd = (m_width * int'({c[2:0], 1'b1})) >>> 3;
    m_pred = c[3] ? m_pred - dd : m_pred + dd;
    if (m_pred > 32'sh7fff) m_pred = 32'sh7fff;
    if (m_pred < -32'sh8000) m_pred = -32'sh8000;
    m_width = (m_width * (c[2] ? fac[c[1:0]] : 32'h0e6)) >>> 8;
    if (m_width > 32'h6000) m_width = 32'h6000;
    if (m_width < 32'h7f) m_width = 32'h7f;
    return m_pred[15:0];
  endfunction
  task automatic run(input logic [1:0] fmt, input logic lp, input logic [15:0] ls,
    input logic [15:0] le, input int n, input logic hold, input logic [3:0] dl);
    logic [15:0] w;
    logic [15:0] e;
    int idx;
    int sh;
    sh = (fmt == 2'h0) ? 0 : ((fmt == 2'h1) ? 1 : 2);
    dly <= dl;
    reg_wr(asp_pkg::REG_START, {23'h0, fmt, 7'h00});
    reg_wr(asp_pkg::REG_LOOP_START, {16'h0, ls});
    reg_wr(asp_pkg::REG_LOOP_END, {16'h0, le});
    got.delete();
    smp_ready <= ~hold;
    reg_wr(asp_pkg::REG_CTRL, {28'h0, fmt, lp, 1'b1});
    reg_rd(asp_pkg::REG_DEC_STATE, d);
    chk(d, 32'h0000007f);
    reg_rd(asp_pkg::REG_CTRL, d);
    chk(d, {28'h0, fmt, lp, 1'b0});
    repeat (n) begin
      @(posedge clk);
      step_p <= 1'b1;
      @(posedge clk);
      step_p <= 1'b0;
      repeat (10) @(posedge clk);
    end
    smp_ready <= 1'b1;
    repeat (40) @(posedge clk);
    idx = 0;
    m_pred = 0;
    m_width = 32'h7f;
    foreach (got[i]) begin
      w = asp_wave_mem_i.mem[{fmt, 6'h00} + (idx >> sh)];
      if (fmt[1]) e = adp(4'(w >> (4 * idx[1:0])));
      else if (fmt[0]) e = {(idx[0] ? w[15:8] : w[7:0]), 8'h00};
      else e = w;
      chk({16'h0, got[i]}, {16'h0, e});
      idx = (idx == le) ? ls + 1 : idx + 1;
    end
    if (lp) begin
      chk({31'h0, playing}, 32'h1);
    end else begin
      chk(got.size(), le + 1);
      chk({31'h0, playing}, 32'h0);
    end
    if (hold) chk(32'(got.size() > 8), 32'h1);
    else if (lp) chk(got.size(), n);
    reg_rd(asp_pkg::REG_STATUS, d);
    chk({31'h0, d[16]}, {31'h0, lp});
    if (fmt[1]) begin
      reg_rd(asp_pkg::REG_DEC_STATE, d);
      chk(d, {m_pred[15:0], 1'b0, m_width[14:0]});
    end
    reg_wr(asp_pkg::REG_CTRL, 32'h00000010);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    for (int k = 0; k < 256; k++) asp_wave_mem_i.mem[k] = {8'(k) + 8'h11, 8'(k)};
    for (int k = 0; k < 3; k++) begin
      asp_wave_mem_i.mem[8'h80 + k] = adp_w[k];
      asp_wave_mem_i.mem[8'hc0 + k] = adp_w[k];
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(asp_pkg::REG_DEC_STATE, d);
    chk(d, 32'h0000007f);
    reg_rd(8'h20, d);
    chk(d, 32'h0);
    // a write while the clock enable is low must leave the register untouched
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(asp_pkg::REG_LOOP_END, 32'h0000abcd);
    ce <= 1'b1;
    reg_rd(asp_pkg::REG_LOOP_END, d);
    chk(d, 32'h0);
    for (int k = 0; k < 4; k++) begin
      reg_wr(asp_pkg::REG_CTRL, 32'h00000020);
      reg_wr(asp_pkg::REG_ENC_IN, {16'h0, enc_in[k]});
      reg_rd(asp_pkg::REG_ENC_CODE, d);
      chk(d, enc_exp[k]);
    end
    run(2'h0, 1'b0, 16'h0, 16'h5, 8, 1'b0, 4'h0);
    // loop of two samples, eight-bit format; consumer stalls so the buffer fills
    run(2'h1, 1'b1, 16'h1, 16'h3, 12, 1'b1, 4'h3);
    run(2'h2, 1'b0, 16'h0, 16'hb, 13, 1'b0, 4'h1);
    // second key-on replays the same decoded stream
    run(2'h2, 1'b0, 16'h0, 16'hb, 13, 1'b0, 4'h2);
    // aligned offsets, format three, settings fixed during play
    run(2'h3, 1'b1, 16'h4, 16'h8, 14, 1'b0, 4'h0);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule // asp_playback_tb

// ---- asp_wave_mem.sv ----
// wave memory model that answers fetch requests after a chosen delay
module asp_wave_mem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_delay,
  input wire logic i_req,
  input wire logic [21:0] i_addr,
  output logic o_ack,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // storage and answer timing
  // ****************************************
  logic [15:0] mem [0:255];
  logic [3:0] wait_cnt;
  // between answers the data lines change every cycle, so a stale word is never mistaken for data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_data <= 16'h0000;
      wait_cnt <= 4'h0;
    end else if (i_req && !o_ack && wait_cnt >= i_delay) begin
      o_ack <= 1'b1;
      o_data <= mem[i_addr[7:0]];
      wait_cnt <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      wait_cnt <= (i_req && !o_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // asp_wave_mem
